// ==== common/epst_pkg.sv ====
// shared constants and types for the page state tracker
package epst_pkg;
    // =====================================================
    // sizes
    localparam int PAGES = 16;
    localparam int PIDX_W = 4;
    localparam int SLOTS = 512;
    localparam int SLOT_BYTES = 8;
    localparam int SLOT_W = 9;
    localparam int SLOT_OFF_W = 12;
    localparam int MEM_AW = PIDX_W + SLOT_W;
    localparam logic [SLOT_OFF_W-1:0] LAST_SLOT_OFF = 12'(SLOT_BYTES * (SLOTS - 1));
    // =====================================================
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CMD = 8'h04;
    localparam logic [7:0] OFF_ATTR = 8'h08;
    localparam logic [7:0] OFF_LADDR = 8'h0C;
    localparam logic [7:0] OFF_VER_LO = 8'h10;
    localparam logic [7:0] OFF_VER_HI = 8'h14;
    localparam logic [7:0] OFF_CTX_LO = 8'h18;
    localparam logic [7:0] OFF_CTX_HI = 8'h1C;
    localparam logic [7:0] OFF_RESULT = 8'h20;
    localparam logic [7:0] OFF_EVV_LO = 8'h24;
    localparam logic [7:0] OFF_EVV_HI = 8'h28;
    localparam logic [7:0] OFF_ISTAT_LO = 8'h2C;
    localparam logic [7:0] OFF_ISTAT_HI = 8'h30;
    localparam logic [7:0] OFF_IFLAG_LO = 8'h34;
    localparam logic [7:0] OFF_IFLAG_HI = 8'h38;
    localparam logic [7:0] OFF_ICTX_LO = 8'h3C;
    localparam logic [7:0] OFF_ICTX_HI = 8'h40;
    // =====================================================
    // field positions
    localparam int CMD_PAGE = 4;
    localparam int CMD_VERPAGE = 8;
    localparam int CMD_SLOT = 12;
    localparam int ATTR_KIND = 8;
    localparam int ATTR_OWNER = 12;
    localparam int ATTR_STATE = 16;
    localparam int FLG_PENDING = 3;
    localparam int FLG_MODIFIED = 4;
    localparam int FLG_RESTRICT = 5;
    localparam int FLG_KIND = 8;
    localparam int FLG_BLOCKED = 63;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [63:0] VERSION_FIRST = 64'h0000_0000_0000_0001;
    // =====================================================
    // types
    typedef enum logic [2:0] {
        KIND_CONTROL = 3'h0, KIND_THREAD_CTL = 3'h1, KIND_REGULAR = 3'h2, KIND_VERSION_ARRAY = 3'h3,
        KIND_TRIMMED = 3'h4, KIND_SHADOW_FIRST = 3'h5, KIND_SHADOW_REST = 3'h6
    } epst_kind_e;
    typedef enum logic [2:0] {
        OP_ADD = 3'h0, OP_EVICT = 3'h1, OP_RELOAD = 3'h2, OP_INFO = 3'h3, OP_STATE = 3'h4
    } epst_op_e;
    typedef enum logic [3:0] {
        ERR_NONE = 4'h0, ERR_PAGE = 4'h1, ERR_VERPAGE = 4'h2, ERR_SLOT_FULL = 4'h3,
        ERR_MISMATCH = 4'h4, ERR_OP = 4'h5
    } epst_err_e;
    typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_EXEC = 1'b1} epst_state_e;
    typedef struct packed {
        logic valid;
        logic rd;
        logic wr;
        logic ex;
        epst_kind_e kind;
        logic [PIDX_W-1:0] ownerControlId;
        logic [31:0] enclaveLinearAddr;
        logic blocked;
        logic pending;
        logic modified;
        logic permRestricted;
        logic [63:0] parentContextPtr;
    } epst_entry_s;
endpackage

// ==== hdl/epst_slot_mem.sv ====
// version slot storage with registered read data
`timescale 1ns/100ps
module epst_slot_mem
    import epst_pkg::*;
#(
    parameter int AW = MEM_AW,
    parameter int DW = 64
)
(
    input wire logic clock,
    input wire logic readEn,
    input wire logic writeEn,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] writeData,
    output logic [DW-1:0] readData
);
    logic [DW-1:0] store [2**AW];

    // no reset on the array: slots start empty by initial clear only in simulation
    initial
    begin
        for (int i = 0; i < 2**AW; i++)
            store[i] = '0;
    end

    always_ff @(posedge clock)
    begin
        if (writeEn)
            store[addr] <= writeData;
        if (readEn)
            readData <= store[addr];
    end
endmodule

// ==== hdl/epst_page_tracker.sv ====
// page security map, version slots and page info record behind an AXI4-Lite slave
// Functional notes
// - each version array page holds 512 eight-byte slots, slot n at byte 8n.
// - on eviction the device writes the page's unique version into the chosen empty slot.
// - reload needs the slot holding the page's version; success clears that slot.
// - an evicted version array page's version lives in another version array page.
// - one map entry per resident page, none for pages not resident.
// - software cannot read or write the map directly.
// - entries hold valid plus read, write, execute permission bits.
// - entries hold one of seven page kinds when added; reload loads any 3-bit kind unchecked.
// - entries record owner control page id and enclave linear address.
// - entries keep blocked, pending, modified, restricted flags.
// - info record: status at 0, flags at 8, parent context at 16.
// - status bit 0 shows children, zero for non-control pages, guest counts virtual.
// - status bit 1 shows virtual children, zero for non-control pages and in guest.
// - flags: rwx bits 0-2, pending/modified/restricted 3-5, kind 15:8, blocked 63.
`timescale 1ns/100ps
module epst_page_tracker
    import epst_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // =====================================================
    // bus slave state and software registers
    logic [7:0] awAddr, next_awAddr;
    logic [31:0] wData, next_wData;
    logic [3:0] wStrb, next_wStrb;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic [1:0] ctrl, next_ctrl;
    logic [31:0] cmd, next_cmd, attr, next_attr, laddr, next_laddr;
    logic [63:0] verIn, next_verIn, ctxIn, next_ctxIn;
    logic startReq;
    logic [31:0] ctrlMerged;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
            if (strb[b])
                res[8*b +: 8] = val[8*b +: 8];
        return res;
    endfunction

    // a function result cannot be part-selected, so the merged word is a net
    assign ctrlMerged = merge({30'h0, ctrl}, wData, wStrb);

    // =====================================================
    // operation state
    epst_state_e state, next_state;
    epst_entry_s map [PAGES];
    epst_entry_s next_map [PAGES];
    logic [63:0] verCtr, next_verCtr, evVer, next_evVer;
    logic done, next_done;
    epst_err_e err, next_err;
    logic [1:0] infoStat, next_infoStat;
    logic [63:0] infoFlags, next_infoFlags, infoCtx, next_infoCtx;
    logic memRe, memWe;
    logic [MEM_AW-1:0] memAddr;
    logic [63:0] memWdata, memRdata;

    wire epst_op_e op = epst_op_e'(cmd[2:0]);
    wire logic [PIDX_W-1:0] pg = cmd[CMD_PAGE +: PIDX_W];
    wire logic [PIDX_W-1:0] verPg = cmd[CMD_VERPAGE +: PIDX_W];
    wire logic [SLOT_OFF_W-1:0] slotOff = cmd[CMD_SLOT +: SLOT_OFF_W];
    wire logic guestMode = ctrl[0];
    wire logic virtKids = ctrl[1];
    wire logic busy = (state == ST_EXEC);
    wire epst_entry_s curPage = map[pg];
    wire epst_entry_s curVerPage = map[verPg];

    // =====================================================
    // AXI4-Lite write and read channels
    always_comb
    begin
        next_awAddr = awAddr;
        next_wData = wData;
        next_wStrb = wStrb;
        next_awready = s_axi_awready;
        next_wready = s_axi_wready;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_arready = s_axi_arready;
        next_rvalid = s_axi_rvalid;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;
        next_ctrl = ctrl;
        next_cmd = cmd;
        next_attr = attr;
        next_laddr = laddr;
        next_verIn = verIn;
        next_ctxIn = ctxIn;
        startReq = 1'b0;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_awAddr = s_axi_awaddr;
            next_awready = 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_wData = s_axi_wdata;
            next_wStrb = s_axi_wstrb;
            next_wready = 1'b0;
        end
        if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid)
        begin
            next_bvalid = 1'b1;
            next_bresp = RESP_OKAY;
            case ({awAddr[7:2], 2'b00})
                OFF_CTRL: next_ctrl = ctrlMerged[1:0];
                OFF_CMD:
                begin
                    // a command written while busy is dropped
                    if (!busy)
                    begin
                        next_cmd = merge(cmd, wData, wStrb);
                        startReq = 1'b1;
                    end
                end
                OFF_ATTR: next_attr = merge(attr, wData, wStrb);
                OFF_LADDR: next_laddr = merge(laddr, wData, wStrb);
                OFF_VER_LO: next_verIn[31:0] = merge(verIn[31:0], wData, wStrb);
                OFF_VER_HI: next_verIn[63:32] = merge(verIn[63:32], wData, wStrb);
                OFF_CTX_LO: next_ctxIn[31:0] = merge(ctxIn[31:0], wData, wStrb);
                OFF_CTX_HI: next_ctxIn[63:32] = merge(ctxIn[63:32], wData, wStrb);
                OFF_RESULT, OFF_EVV_LO, OFF_EVV_HI, OFF_ISTAT_LO, OFF_ISTAT_HI,
                OFF_IFLAG_LO, OFF_IFLAG_HI, OFF_ICTX_LO, OFF_ICTX_HI: next_bresp = RESP_OKAY;
                default: next_bresp = RESP_SLVERR;
            endcase
        end
        if (s_axi_bvalid && s_axi_bready)
        begin
            next_bvalid = 1'b0;
            next_awready = 1'b1;
            next_wready = 1'b1;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_arready = 1'b0;
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            // the map itself has no read path; only the info record is visible
            case ({s_axi_araddr[7:2], 2'b00})
                OFF_CTRL: next_rdata = {30'h0, ctrl};
                OFF_CMD: next_rdata = cmd;
                OFF_ATTR: next_rdata = attr;
                OFF_LADDR: next_rdata = laddr;
                OFF_VER_LO: next_rdata = verIn[31:0];
                OFF_VER_HI: next_rdata = verIn[63:32];
                OFF_CTX_LO: next_rdata = ctxIn[31:0];
                OFF_CTX_HI: next_rdata = ctxIn[63:32];
                OFF_RESULT: next_rdata = {24'h0, err, 2'b00, done, busy};
                OFF_EVV_LO: next_rdata = evVer[31:0];
                OFF_EVV_HI: next_rdata = evVer[63:32];
                OFF_ISTAT_LO: next_rdata = {30'h0, infoStat};
                OFF_ISTAT_HI: next_rdata = 32'h0000_0000;
                OFF_IFLAG_LO: next_rdata = infoFlags[31:0];
                OFF_IFLAG_HI: next_rdata = infoFlags[63:32];
                OFF_ICTX_LO: next_rdata = infoCtx[31:0];
                OFF_ICTX_HI: next_rdata = infoCtx[63:32];
                default:
                begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = RESP_SLVERR;
                end
            endcase
        end
        if (s_axi_rvalid && s_axi_rready)
        begin
            next_rvalid = 1'b0;
            next_arready = 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            awAddr <= 8'h00;
            wData <= 32'h0000_0000;
            wStrb <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            ctrl <= 2'h0;
            cmd <= 32'h0000_0000;
            attr <= 32'h0000_0000;
            laddr <= 32'h0000_0000;
            verIn <= 64'h0;
            ctxIn <= 64'h0;
        end
        else
        begin
            awAddr <= next_awAddr;
            wData <= next_wData;
            wStrb <= next_wStrb;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
            ctrl <= next_ctrl;
            cmd <= next_cmd;
            attr <= next_attr;
            laddr <= next_laddr;
            verIn <= next_verIn;
            ctxIn <= next_ctxIn;
        end
    end

    // =====================================================
    // operation engine: slot read in the start cycle, decision one cycle later
    epst_slot_mem slots (
        .clock(clock),
        .readEn(memRe),
        .writeEn(memWe),
        .addr(memAddr),
        .writeData(memWdata),
        .readData(memRdata)
    );

    logic verPageOk, kidAny;
    epst_entry_s loaded;

    always_comb
    begin
        next_state = state;
        next_map = map;
        next_verCtr = verCtr;
        next_evVer = evVer;
        next_done = done;
        next_err = err;
        next_infoStat = infoStat;
        next_infoFlags = infoFlags;
        next_infoCtx = infoCtx;
        memRe = 1'b0;
        memWe = 1'b0;
        memWdata = 64'h0;
        // the start cycle reads the slot named by the incoming command word
        if (busy)
            memAddr = {verPg, slotOff[3 +: SLOT_W]};
        else
            memAddr = {next_cmd[CMD_VERPAGE +: PIDX_W], next_cmd[CMD_SLOT + 3 +: SLOT_W]};
        // a second version array page must hold the slot, aligned on 8 bytes
        verPageOk = curVerPage.valid && curVerPage.kind == KIND_VERSION_ARRAY && verPg != pg
            && slotOff[2:0] == 3'h0;
        kidAny = 1'b0;
        for (int i = 0; i < PAGES; i++)
            if (map[i].valid && map[i].ownerControlId == pg && PIDX_W'(i) != pg)
                kidAny = 1'b1;
        loaded = '{valid: 1'b1, rd: attr[0], wr: attr[1], ex: attr[2],
            kind: epst_kind_e'(attr[ATTR_KIND +: 3]), ownerControlId: attr[ATTR_OWNER +: PIDX_W],
            enclaveLinearAddr: laddr, blocked: attr[ATTR_STATE], pending: attr[ATTR_STATE+1],
            modified: attr[ATTR_STATE+2], permRestricted: attr[ATTR_STATE+3], parentContextPtr: ctxIn};
        case (state)
            ST_IDLE:
            begin
                if (startReq)
                begin
                    memRe = 1'b1;
                    next_state = ST_EXEC;
                    next_done = 1'b0;
                end
            end
            ST_EXEC:
            begin
                next_state = ST_IDLE;
                next_done = 1'b1;
                next_err = ERR_NONE;
                case (op)
                    OP_ADD:
                    begin
                        if (curPage.valid || loaded.kind > KIND_SHADOW_REST)
                            next_err = ERR_PAGE;
                        else
                            next_map[pg] = loaded;
                    end
                    OP_EVICT:
                    begin
                        if (!curPage.valid)
                            next_err = ERR_PAGE;
                        else if (!verPageOk)
                            next_err = ERR_VERPAGE;
                        else if (memRdata != 64'h0)
                            next_err = ERR_SLOT_FULL;
                        else
                        begin
                            memWe = 1'b1;
                            memWdata = verCtr;
                            next_evVer = verCtr;
                            next_verCtr = verCtr + 64'h1;
                            next_map[pg].valid = 1'b0;
                        end
                    end
                    OP_RELOAD:
                    begin
                        if (curPage.valid)
                            next_err = ERR_PAGE;
                        else if (!verPageOk)
                            next_err = ERR_VERPAGE;
                        else if (memRdata == 64'h0 || memRdata != verIn)
                            next_err = ERR_MISMATCH;
                        else
                        begin
                            memWe = 1'b1;
                            next_map[pg] = loaded;
                        end
                    end
                    OP_INFO:
                    begin
                        if (!curPage.valid)
                            next_err = ERR_PAGE;
                        else
                        begin
                            // non-control pages never report children
                            next_infoStat[0] = curPage.kind == KIND_CONTROL && (kidAny || (guestMode && virtKids));
                            next_infoStat[1] = curPage.kind == KIND_CONTROL && !guestMode && virtKids;
                            next_infoFlags = 64'h0;
                            next_infoFlags[2:0] = {curPage.ex, curPage.wr, curPage.rd};
                            next_infoFlags[FLG_PENDING] = curPage.pending;
                            next_infoFlags[FLG_MODIFIED] = curPage.modified;
                            next_infoFlags[FLG_RESTRICT] = curPage.permRestricted;
                            next_infoFlags[FLG_KIND +: 8] = {5'h00, curPage.kind};
                            next_infoFlags[FLG_BLOCKED] = curPage.blocked;
                            next_infoCtx = curPage.parentContextPtr;
                        end
                    end
                    OP_STATE:
                    begin
                        if (!curPage.valid)
                            next_err = ERR_PAGE;
                        else
                        begin
                            next_map[pg].blocked = loaded.blocked;
                            next_map[pg].pending = loaded.pending;
                            next_map[pg].modified = loaded.modified;
                            next_map[pg].permRestricted = loaded.permRestricted;
                        end
                    end
                    default: next_err = ERR_OP;
                endcase
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            state <= ST_IDLE;
            for (int i = 0; i < PAGES; i++)
                map[i] <= '0;
            verCtr <= VERSION_FIRST;
            evVer <= 64'h0;
            done <= 1'b0;
            err <= ERR_NONE;
            infoStat <= 2'h0;
            infoFlags <= 64'h0;
            infoCtx <= 64'h0;
        end
        else
        begin
            state <= next_state;
            map <= next_map;
            verCtr <= next_verCtr;
            evVer <= next_evVer;
            done <= next_done;
            err <= next_err;
            infoStat <= next_infoStat;
            infoFlags <= next_infoFlags;
            infoCtx <= next_infoCtx;
        end
    end

    // =====================================================
    // checks
    AST_SLOT_ALIGN: assert property (@(posedge clock) disable iff (srst)
        state == ST_EXEC && op == OP_EVICT && curPage.valid && slotOff[2:0] != 3'h0 |=> done && err == ERR_VERPAGE)
        else $error("misaligned slot offset accepted");
    AST_EVICT_WRITE: assert property (@(posedge clock) disable iff (srst)
        state == ST_EXEC && op == OP_EVICT && memWe |-> memWdata == verCtr ##1 evVer == $past(verCtr))
        else $error("evicted version not written to slot");
    AST_RELOAD_CLEAR: assert property (@(posedge clock) disable iff (srst)
        state == ST_EXEC && op == OP_RELOAD && memWe |-> memWdata == 64'h0 && memRdata == verIn)
        else $error("reload did not clear a matching slot");
    AST_OTHER_VERPAGE: assert property (@(posedge clock) disable iff (srst)
        memWe |-> verPg != pg && curVerPage.kind == KIND_VERSION_ARRAY)
        else $error("slot written in own or non version array page");
    AST_EVICT_DROPS: assert property (@(posedge clock) disable iff (srst)
        state == ST_EXEC && op == OP_EVICT && memWe |=> !curPage.valid && err == ERR_NONE)
        else $error("evicted page still resident");
    AST_ADD_FIELDS: assert property (@(posedge clock) disable iff (srst)
        state == ST_EXEC && op == OP_ADD && !curPage.valid && attr[ATTR_KIND +: 3] != 3'h7
        |=> curPage.valid && curPage.kind == attr[ATTR_KIND +: 3] && curPage.enclaveLinearAddr == laddr)
        else $error("added entry does not match request");
    AST_MISMATCH_KEEP: assert property (@(posedge clock) disable iff (srst)
        state == ST_EXEC && op == OP_RELOAD && next_err == ERR_MISMATCH |-> !memWe ##1 !curPage.valid)
        else $error("mismatching reload changed state");
    AST_GUEST_VIRT: assert property (@(posedge clock) disable iff (srst)
        state == ST_EXEC && op == OP_INFO && guestMode |=> infoStat[1] == 1'b0)
        else $error("virtual child bit set in guest mode");
    AST_INFO_BLOCKED: assert property (@(posedge clock) disable iff (srst)
        state == ST_EXEC && op == OP_INFO && curPage.valid |=> infoFlags[FLG_BLOCKED] == $past(curPage.blocked))
        else $error("info flags blocked bit wrong");
endmodule

// ==== tb/epst_sw_model.sv ====
// software-side register bus master issuing page operations
`timescale 1ns/100ps
module epst_sw_model
    import epst_pkg::*;
(
    input wire logic clock,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    initial {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    initial {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 4'hF, 3'h7};
        for (n = 0; n < 64; n++)
        begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            r = s_axi_bresp;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        if (n == 64) testbench.hang();
        // one idle edge so the next call never reassigns bready in this time step
        @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        for (n = 0; n < 64; n++)
        begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            d = s_axi_rdata;
            r = s_axi_rresp;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        if (n == 64) testbench.hang();
        @(posedge clock);
    endtask
endmodule

// ==== tb/testbench.sv ====
// page tracker bench: operation sequences over the register bus
`timescale 1ns/100ps
module testbench import epst_pkg::*;;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int mismatches = 0;
    int compares = 0;
    always #5 clock = ~clock;
    epst_page_tracker u_epst_page_tracker (.*);
    epst_sw_model u_epst_sw_model (.*);
    task automatic stop_test();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic hang();
        mismatches++;
        $display("[ERR] %0t bus timeout", $time);
        stop_test();
    endtask
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        u_epst_sw_model.wr(a, d, r);
        compares++;
        if (r !== (a > OFF_ICTX_HI ? RESP_SLVERR : RESP_OKAY))
        begin
            mismatches++;
            $display("[ERR] %0t write addr %h resp %h", $time, a, r);
        end
    endtask
    // unmapped offsets above the last register answer with an error
    task automatic chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        u_epst_sw_model.rd(a, d, r);
        compares++;
        if (d !== e || r !== (a > OFF_ICTX_HI ? RESP_SLVERR : RESP_OKAY))
        begin
            mismatches++;
            $display("[ERR] %0t addr %h got %h exp %h", $time, a, d, e);
        end
    endtask
    function automatic logic [31:0] cmd(input int op, pg, verPg, off);
        return 32'(op) | 32'(pg) << CMD_PAGE | 32'(verPg) << CMD_VERPAGE | 32'(off) << CMD_SLOT;
    endfunction
    task automatic go(input logic [31:0] c, input logic [3:0] e);
        w(OFF_CMD, c);
        chk(OFF_RESULT, {24'h0, e, 4'h2});
    endtask
    initial
    begin
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        chk(8'hFC, 32'h0);
        w(OFF_CTX_LO, 32'hCAFE_0001);
        w(OFF_ATTR, 32'h0000_0207);
        go(cmd(0, 1, 0, 0), 4'h0);
        go(cmd(0, 1, 0, 0), 4'h1);
        go(cmd(3, 1, 0, 0), 4'h0);
        chk(OFF_IFLAG_LO, 32'h0000_0207);
        chk(OFF_ICTX_LO, 32'hCAFE_0001);
        chk(OFF_ISTAT_LO, 32'h0);
        w(OFF_ATTR, 32'h0000_0007);
        go(cmd(0, 0, 0, 0), 4'h0);
        w(OFF_CTRL, 32'h2);
        go(cmd(3, 0, 0, 0), 4'h0);
        chk(OFF_ISTAT_LO, 32'h3);
        chk(OFF_ISTAT_HI, 32'h0);
        w(OFF_CTRL, 32'h3);
        go(cmd(3, 0, 0, 0), 4'h0);
        chk(OFF_ISTAT_LO, 32'h1);
        w(OFF_ATTR, 32'h0000_0307);
        go(cmd(0, 2, 0, 0), 4'h0);
        go(cmd(1, 2, 2, 0), 4'h2);
        go(cmd(1, 1, 2, 4088), 4'h0);
        chk(OFF_EVV_LO, 32'h1);
        go(cmd(3, 1, 0, 0), 4'h1);
        w(OFF_ATTR, 32'h000F_0207);
        w(OFF_VER_LO, 32'h5);
        go(cmd(2, 1, 2, 4088), 4'h4);
        w(OFF_VER_LO, 32'h1);
        go(cmd(2, 1, 2, 4088), 4'h0);
        go(cmd(3, 1, 0, 0), 4'h0);
        chk(OFF_IFLAG_LO, 32'h0000_023F);
        chk(OFF_IFLAG_HI, 32'h8000_0000);
        w(OFF_ATTR, 32'h000A_0207);
        go(cmd(4, 1, 0, 0), 4'h0);
        go(cmd(3, 1, 0, 0), 4'h0);
        chk(OFF_IFLAG_LO, 32'h0000_022F);
        chk(OFF_IFLAG_HI, 32'h0);
        go(cmd(1, 1, 2, 4088), 4'h0);
        chk(OFF_EVV_LO, 32'h2);
        go(cmd(1, 0, 2, 4088), 4'h3);
        go(cmd(1, 0, 2, 4), 4'h2);
        go(cmd(5, 0, 0, 0), 4'h5);
        w(OFF_ATTR, 32'h0000_0707);
        go(cmd(0, 3, 0, 0), 4'h1);
        w(8'hFC, 32'h0);
        stop_test();
    end
endmodule
